// file: verilog/scms_pkg.sv
// Package: constants and types for the configuration and mode sequencer
package scms_pkg;
	// Load schemes
	typedef enum logic [1:0]
	{
		SCMS_SCHEME_MEMORY,
		SCMS_SCHEME_SYNC_SERIAL,
		SCMS_SCHEME_ASYNC_SERIAL
	} scms_scheme_e;

	// Sequencer states
	typedef enum logic [2:0]
	{
		SCMS_POWERUP,
		SCMS_LOAD,
		SCMS_INIT,
		SCMS_USER
	} scms_state_e;

	// Configuration image length in bits
	localparam int SCMS_IMAGE_BITS = 256;
	localparam int SCMS_BITCNT_W = 16;
	localparam logic [15:0] SCMS_BITCNT_LAST = 16'(SCMS_IMAGE_BITS - 1);
	// Initialization phase length in cycles
	localparam int SCMS_INIT_CYCLES = 16;
	localparam logic [7:0] SCMS_INIT_LAST = 8'(SCMS_INIT_CYCLES - 1);
	// Reconfiguration budget
	localparam int SCMS_CLK_HZ = 20000000;
	localparam int SCMS_RECONF_MS = 100;
	localparam longint SCMS_RECONF_CYCLES_L =
		longint'(SCMS_CLK_HZ) * SCMS_RECONF_MS / 1000 - 1;
	localparam logic [23:0] SCMS_RECONF_CYCLES =
		24'(SCMS_RECONF_CYCLES_L);
	// Async serial sampling: bit taken after this many stable cycles
	localparam logic [1:0] SCMS_ASYNC_STABLE = 2'h2;
	// Reset values
	localparam logic [15:0] SCMS_BITCNT_RST = 16'h0000;
	localparam logic [7:0] SCMS_INIT_RST = 8'h00;
	localparam logic [23:0] SCMS_TIMER_RST = 24'h000000;
endpackage

// file: verilog/scms_bit_if.sv
// Interface: configuration bit stream from the input stage to the sequencer
`timescale 1ns/1ns
interface scms_bit_if;
	logic bitValid;
	logic bitData;
	logic enable;
	modport source
	(
		output bitValid,
		output bitData,
		input enable
	);
	modport sink
	(
		input bitValid,
		input bitData,
		output enable
	);
endinterface // scms_bit_if

// file: verilog/scms_bit_capture.sv
// Module: picks one configuration bit source according to the load scheme
`timescale 1ns/1ns
module scms_bit_capture
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire scms_pkg::scms_scheme_e scheme,
	input wire logic memData,
	input wire logic memValid,
	input wire logic serialClk,
	input wire logic serialData,
	input wire logic asyncData,
	input wire logic asyncStrobe,
	scms_bit_if.source bits
);
	logic serialClk_reg, serialClk_next;
	logic asyncStrobe_reg, asyncStrobe_next;
	logic [1:0] stable_reg, stable_next;
	logic bitValid_reg, bitValid_next;
	logic bitData_reg, bitData_next;

	always_comb
	begin
		serialClk_next = serialClk;
		asyncStrobe_next = asyncStrobe;
		stable_next = stable_reg;
		bitValid_next = 1'b0;
		bitData_next = bitData_reg;
		if (asyncStrobe && !asyncStrobe_reg)
			stable_next = 2'h1;
		else if (stable_reg != 2'h0)
			stable_next = stable_reg + 2'h1;
		if (bits.enable)
		begin
			unique case (scheme)
				scms_pkg::SCMS_SCHEME_MEMORY:
				begin
					bitValid_next = memValid;
					bitData_next = memData;
				end
				scms_pkg::SCMS_SCHEME_SYNC_SERIAL:
				begin
					// Rising edge of the serial clock
					bitValid_next = serialClk && !serialClk_reg;
					bitData_next = serialData;
				end
				scms_pkg::SCMS_SCHEME_ASYNC_SERIAL:
				begin
					// Take the bit once it has settled after the strobe
					bitValid_next = stable_reg == scms_pkg::SCMS_ASYNC_STABLE;
					bitData_next = asyncData;
				end
				default:
				begin
					bitValid_next = 1'b0;
				end
			endcase
		end
		if (stable_reg == scms_pkg::SCMS_ASYNC_STABLE)
			stable_next = 2'h0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			serialClk_reg <= 1'b0;
			asyncStrobe_reg <= 1'b0;
			stable_reg <= 2'h0;
			bitValid_reg <= 1'b0;
			bitData_reg <= 1'b0;
		end
		else
		begin
			serialClk_reg <= serialClk_next;
			asyncStrobe_reg <= asyncStrobe_next;
			stable_reg <= stable_next;
			bitValid_reg <= bitValid_next;
			bitData_reg <= bitData_next;
		end
	end

	assign bits.bitValid = bitValid_reg;
	assign bits.bitData = bitData_reg;
endmodule // scms_bit_capture

// file: verilog/scms_sequencer.sv
// Module: configuration loading, initialization and user mode sequencing
`timescale 1ns/1ns
// Behaviour
// - Configuration cells lose content, so a full image loads after power-up.
// - Right after loading, an init phase resets user logic and enables I/O.
// - User I/O stays high impedance at power-up and throughout loading.
// - Command mode spans loading and init; user mode follows only after it.
// - A dedicated pin forces command mode, then reload, reinit and resume.
// - A whole reconfiguration finishes within 100 ms; an overrun only raises reconfigTimeout.
// - Data arrives by exactly one of three selectable load schemes.
// - Chain enable output feeds the next device's chain enable input.
module scms_sequencer
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reconfigRequest,
	input wire scms_pkg::scms_scheme_e scheme,
	input wire logic chain_enable_in_n,
	input wire logic memData,
	input wire logic memValid,
	input wire logic serialClk,
	input wire logic serialData,
	input wire logic asyncData,
	input wire logic asyncStrobe,
	output logic chain_enable_out_n,
	output logic userIoEnable,
	output logic userRegReset,
	output logic commandMode,
	output logic configDone,
	output logic reconfigTimeout,
	output logic [scms_pkg::SCMS_IMAGE_BITS-1:0] configImage
);
	////////////////////////////////////////////////////////////////////////
	// Bit capture
	scms_bit_if bits ();
	scms_pkg::scms_state_e state_reg, state_next;
	logic [15:0] bitCnt_reg, bitCnt_next;
	logic [7:0] initCnt_reg, initCnt_next;
	logic [23:0] timer_reg, timer_next;
	logic timing_reg, timing_next;
	logic [scms_pkg::SCMS_IMAGE_BITS-1:0] image_reg, image_next;
	logic ceo_reg, ceo_next;
	logic ioEn_reg, ioEn_next;
	logic regRst_reg, regRst_next;
	logic cmd_reg, cmd_next;
	logic done_reg, done_next;
	logic tmo_reg, tmo_next;
	logic request_reg;
	logic reconfigEdge;
	logic initDone;

	scms_bit_capture capture
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.scheme(scheme),
		.memData(memData),
		.memValid(memValid),
		.serialClk(serialClk),
		.serialData(serialData),
		.asyncData(asyncData),
		.asyncStrobe(asyncStrobe),
		.bits(bits.source)
	);

	// Accept bits only while loading and selected by the chain
	assign bits.enable = (state_reg == scms_pkg::SCMS_LOAD)
		&& !chain_enable_in_n;

	// Rising edge of the reconfiguration pin
	assign reconfigEdge = reconfigRequest && !request_reg;
	assign initDone = (state_reg == scms_pkg::SCMS_INIT)
		&& (initCnt_reg == scms_pkg::SCMS_INIT_LAST);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb
	begin
		state_next = state_reg;
		bitCnt_next = bitCnt_reg;
		initCnt_next = initCnt_reg;
		image_next = image_reg;
		ceo_next = ceo_reg;
		ioEn_next = ioEn_reg;
		regRst_next = regRst_reg;
		cmd_next = cmd_reg;
		done_next = done_reg;
		unique case (state_reg)
			scms_pkg::SCMS_POWERUP:
			begin
				// Nothing is held over a power-up; loading starts at once
				state_next = scms_pkg::SCMS_LOAD;
				bitCnt_next = scms_pkg::SCMS_BITCNT_RST;
				ioEn_next = 1'b0;
				cmd_next = 1'b1;
			end
			scms_pkg::SCMS_LOAD:
			begin
				ioEn_next = 1'b0;
				regRst_next = 1'b1;
				cmd_next = 1'b1;
				if (bits.bitValid && !chain_enable_in_n)
				begin
					image_next = {bits.bitData,
						image_reg[scms_pkg::SCMS_IMAGE_BITS-1:1]};
					bitCnt_next = bitCnt_reg + 16'h0001;
					if (bitCnt_reg == scms_pkg::SCMS_BITCNT_LAST)
					begin
						state_next = scms_pkg::SCMS_INIT;
						initCnt_next = scms_pkg::SCMS_INIT_RST;
						ceo_next = 1'b0;
					end
				end
			end
			scms_pkg::SCMS_INIT:
			begin
				regRst_next = 1'b1;
				initCnt_next = initCnt_reg + 8'h01;
				if (initCnt_reg == scms_pkg::SCMS_INIT_LAST)
				begin
					state_next = scms_pkg::SCMS_USER;
					regRst_next = 1'b0;
					ioEn_next = 1'b1;
					cmd_next = 1'b0;
					done_next = 1'b1;
				end
			end
			scms_pkg::SCMS_USER:
			begin
				cmd_next = 1'b0;
			end
			default:
			begin
				state_next = scms_pkg::SCMS_POWERUP;
			end
		endcase
		// Reconfiguration pin wins from any state
		if (reconfigEdge)
		begin
			state_next = scms_pkg::SCMS_LOAD;
			bitCnt_next = scms_pkg::SCMS_BITCNT_RST;
			ioEn_next = 1'b0;
			regRst_next = 1'b1;
			cmd_next = 1'b1;
			done_next = 1'b0;
			ceo_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_reg <= scms_pkg::SCMS_POWERUP;
			bitCnt_reg <= scms_pkg::SCMS_BITCNT_RST;
			initCnt_reg <= scms_pkg::SCMS_INIT_RST;
			image_reg <= '0;
			ceo_reg <= 1'b1;
			ioEn_reg <= 1'b0;
			regRst_reg <= 1'b1;
			cmd_reg <= 1'b1;
			done_reg <= 1'b0;
			request_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			bitCnt_reg <= bitCnt_next;
			initCnt_reg <= initCnt_next;
			image_reg <= image_next;
			ceo_reg <= ceo_next;
			ioEn_reg <= ioEn_next;
			regRst_reg <= regRst_next;
			cmd_reg <= cmd_next;
			done_reg <= done_next;
			request_reg <= reconfigRequest;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reconfiguration budget timer
	always_comb
	begin
		timer_next = timer_reg;
		timing_next = timing_reg;
		tmo_next = tmo_reg;
		if (reconfigEdge)
		begin
			// A new request restarts the budget
			timer_next = scms_pkg::SCMS_TIMER_RST;
			timing_next = 1'b1;
			// An overrun landing on this same cycle still shows
			tmo_next = timing_reg
				&& (timer_reg == scms_pkg::SCMS_RECONF_CYCLES);
		end
		else if (timing_reg)
		begin
			// Stop timing once user mode is reached
			if (initDone)
				timing_next = 1'b0;
			// Flag a reconfiguration that overruns its budget
			if (timer_reg == scms_pkg::SCMS_RECONF_CYCLES)
			begin
				tmo_next = 1'b1;
				timing_next = 1'b0;
			end
			else
				timer_next = timer_reg + 24'h000001;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			timer_reg <= scms_pkg::SCMS_TIMER_RST;
			timing_reg <= 1'b0;
			tmo_reg <= 1'b0;
		end
		else
		begin
			timer_reg <= timer_next;
			timing_reg <= timing_next;
			tmo_reg <= tmo_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign chain_enable_out_n = ceo_reg;
	assign userIoEnable = ioEn_reg;
	assign userRegReset = regRst_reg;
	assign commandMode = cmd_reg;
	assign configDone = done_reg;
	assign reconfigTimeout = tmo_reg;
	assign configImage = image_reg;
endmodule // scms_sequencer

// file: verif/scms_config_source.sv
// Partner: configuration source feeding the three load schemes
`timescale 1ns/1ns
module scms_config_source
(
	input wire logic ref_clk,
	output logic memData,
	output logic memValid,
	output logic serialClk,
	output logic serialData,
	output logic asyncData,
	output logic asyncStrobe
);
	initial
	begin
		{memData, memValid, serialClk, serialData} = 4'h0;
		{asyncData, asyncStrobe} = 2'h0;
	end
	// Whole image, first bit first; data lines flip once released
	task automatic send(
		input logic [scms_pkg::SCMS_IMAGE_BITS-1:0] img,
		input scms_pkg::scms_scheme_e s);
		for (int i = 0; i < scms_pkg::SCMS_IMAGE_BITS; i++)
		begin
			@(posedge ref_clk) #2;
			case (s)
				scms_pkg::SCMS_SCHEME_MEMORY:
				begin
					memValid = 1'b1;
					memData = img[i];
				end
				scms_pkg::SCMS_SCHEME_SYNC_SERIAL:
				begin
					serialData = img[i];
					@(posedge ref_clk) #2 serialClk = 1'b1;
					@(posedge ref_clk) #2 serialClk = 1'b0;
				end
				default:
				begin
					asyncData = img[i];
					asyncStrobe = 1'b1;
					@(posedge ref_clk) #2 asyncStrobe = 1'b0;
					repeat (3) @(posedge ref_clk);
				end
			endcase
		end
		@(posedge ref_clk) #2;
		memValid = 1'b0;
		memData = ~memData;
		serialData = ~serialData;
		asyncData = ~asyncData;
	endtask
endmodule // scms_config_source

// file: verif/scms_sequencer_properties.sv
// Checker: mode sequencing properties at the sequencer ports
`timescale 1ns/1ns
module scms_sequencer_properties
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reconfigRequest,
	input wire logic chain_enable_in_n,
	input wire logic chain_enable_out_n,
	input wire logic userIoEnable,
	input wire logic userRegReset,
	input wire logic commandMode,
	input wire logic configDone,
	input wire logic [scms_pkg::SCMS_IMAGE_BITS-1:0] configImage
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_io_tristate: assert property (commandMode |-> !userIoEnable)
		else $error("user io enabled in command mode");
	a_mode_excl: assert property (commandMode != configDone)
		else $error("command and user mode overlap");
	a_reg_reset: assert property (userRegReset == commandMode)
		else $error("user register reset out of step");
	a_ceo_done: assert property (configDone |-> !chain_enable_out_n)
		else $error("chain out high in user mode");
	a_init_user: assert property ($fell(chain_enable_out_n)
		|-> !configDone[*8] ##1 !configDone[*8] ##1 configDone)
		else $error("init phase length wrong");
	a_reconf_entry: assert property ($rose(reconfigRequest)
		|=> commandMode && chain_enable_out_n && !configDone)
		else $error("request did not force command mode");
	a_done_cause: assert property ($fell(configDone)
		|-> $past(reconfigRequest) && !$past(reconfigRequest, 2))
		else $error("user mode left without request");
	a_chain_block: assert property (chain_enable_in_n[*2]
		##0 $stable(commandMode) |-> $stable(configImage))
		else $error("image moved while chain in high");
	a_image_hold: assert property (configDone |-> $stable(configImage))
		else $error("image moved in user mode");
	c_done: cover property ($rose(configDone));
	c_reconf: cover property ($rose(reconfigRequest) ##1 commandMode);
	c_block: cover property (chain_enable_in_n && commandMode);
endmodule // scms_sequencer_properties

// file: verif/sram_config_mode_sequencer_tb_top.sv
// Testbench: refusal, load and reconfiguration scenarios
`timescale 1ns/1ns
module sram_config_mode_sequencer_tb_top;
	localparam logic [255:0] IMG_A = {8{32'h5a3c_96e1}};
	localparam logic [255:0] IMG_B = {8{32'h0ff1_a7c3}};
	localparam logic [255:0] IMG_C = {16{16'hb4d2}};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic reconfigRequest = 1'b0;
	logic chain_enable_in_n = 1'b1;
	scms_pkg::scms_scheme_e scheme = scms_pkg::SCMS_SCHEME_MEMORY;
	logic memData, memValid, serialClk, serialData, asyncData, asyncStrobe;
	logic chain_enable_out_n, userIoEnable, userRegReset, commandMode;
	logic configDone, reconfigTimeout;
	logic [scms_pkg::SCMS_IMAGE_BITS-1:0] configImage;
	int miscompares = 0;
	int total_checks = 0;
	always #25 ref_clk = ~ref_clk;
	scms_config_source src (.ref_clk, .memData, .memValid, .serialClk,
		.serialData, .asyncData, .asyncStrobe);
	scms_sequencer dut (.ref_clk, .rst, .reconfigRequest, .scheme,
		.chain_enable_in_n, .memData, .memValid, .serialClk, .serialData,
		.asyncData, .asyncStrobe, .chain_enable_out_n, .userIoEnable,
		.userRegReset, .commandMode, .configDone, .reconfigTimeout,
		.configImage);
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [255:0] e,
		input logic [255:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic test_done;
		if (miscompares == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_refused;
		src.send(IMG_A, scms_pkg::SCMS_SCHEME_MEMORY);
		repeat (20) @(posedge ref_clk);
		#2;
		chk("image", '0, configImage);
		chk("ceo", 1, chain_enable_out_n);
		chk("ioEn", 0, userIoEnable);
		// Unused scheme code: bits refused even with the chain selected
		scheme = scms_pkg::scms_scheme_e'(2'h3);
		chain_enable_in_n = 1'b0;
		src.send(IMG_B, scms_pkg::SCMS_SCHEME_ASYNC_SERIAL);
		repeat (4) @(posedge ref_clk);
		#2;
		chk("image", '0, configImage);
		chk("regRst", 1, userRegReset);
		chk("cmd", 1, commandMode);
		chk("ioEn", 0, userIoEnable);
		scheme = scms_pkg::SCMS_SCHEME_MEMORY;
	endtask
	task automatic t_load(input logic [255:0] img,
		input scms_pkg::scms_scheme_e s);
		int n;
		chain_enable_in_n = 1'b0;
		chk("cmd", 1, commandMode);
		src.send(img, s);
		chk("ioEn", 0, userIoEnable);
		for (n = 0; n < 100 && configDone !== 1'b1; n++)
		begin
			@(posedge ref_clk) #2;
		end
		chk("done", 1, configDone);
		chk("ceo", 0, chain_enable_out_n);
		chk("ioEn", 1, userIoEnable);
		chk("regRst", 0, userRegReset);
		chk("cmd", 0, commandMode);
		chk("image", img, configImage);
		chk("timeout", 0, reconfigTimeout);
	endtask
	task automatic t_reconf(input logic [255:0] img,
		input scms_pkg::scms_scheme_e s);
		scheme = s;
		@(posedge ref_clk) #2 reconfigRequest = 1'b1;
		repeat (2) @(posedge ref_clk);
		#2 reconfigRequest = 1'b0;
		chk("done", 0, configDone);
		chk("ceo", 1, chain_enable_out_n);
		chk("regRst", 1, userRegReset);
		chk("ioEn", 0, userIoEnable);
		t_load(img, s);
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge ref_clk);
		#2 rst = 1'b0;
		repeat (2) @(posedge ref_clk);
		t_refused();
		t_load(IMG_A, scms_pkg::SCMS_SCHEME_MEMORY);
		t_reconf(IMG_B, scms_pkg::SCMS_SCHEME_SYNC_SERIAL);
		t_reconf(IMG_C, scms_pkg::SCMS_SCHEME_ASYNC_SERIAL);
		test_done();
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		test_done();
	end
endmodule // sram_config_mode_sequencer_tb_top
bind scms_sequencer scms_sequencer_properties props (.ref_clk, .rst,
	.reconfigRequest, .chain_enable_in_n, .chain_enable_out_n,
	.userIoEnable, .userRegReset, .commandMode, .configDone, .configImage);
